// >>> rtl/sio_signal_assign.sv
// Top of the servo I/O signal assignment block: parameters, routing, outputs, registers.
//
// Overview of operation
// - Each input slot is bound to one function.
// - First variant: seven slots, codes 1 to 58.
// - First variant: physical slots take only terminal functions.
// - First variant: image slots six, seven take limited functions.
// - Other image input bits have fixed functions.
// - Output terminals show their selected status.
// - Output codes include status, alarm, pass-through.
// - Fixed image output bits are always driven.
// - Second variant: nineteen slots, codes 1 to 76.
// - New assignments act only after power cycle.
module sio_signal_assign #(
  parameter logic VARIANT_B = 1'b0                     // Low: 7-slot variant, high: 19-slot.
) (
  input  wire logic                        mclk,          // 40 MHz clock.
  input  wire logic                        reset,         // Synchronous, active high.
  input  wire logic                        power_load,    // Pulse: power-up latch of parameters.
  input  wire logic [7:0]                  addr,          // Register byte address.
  input  wire logic [31:0]                 wdata,         // Register write data.
  input  wire logic                        wr,            // Write strobe.
  input  wire logic                        rd,            // Read strobe.
  output logic      [31:0]                 rdata,         // Read data, cycle after rd.
  output logic                             irq,           // Level interrupt.
  input  wire logic [4:0]                  phys_in,       // Sequence input terminal pins.
  input  wire sio_pkg::sio_iq_in_s         iq_in,         // Image-area inputs from controller.
  input  wire logic [sio_pkg::FUNC_N-1:0]  status_vec,    // Internal status by output code.
  input  wire sio_pkg::sio_aux_s           aux_status,    // Internal status without a code.
  output logic      [sio_pkg::FUNC_N-1:0]  func_active,   // Input functions now requested.
  output sio_pkg::sio_iq_fix_s             fixed_cmd,     // Fixed image-area commands.
  output logic      [1:0]                  out_term,      // Output terminal levels.
  output sio_pkg::sio_iq_out_s             iq_out         // Fixed image-area outputs.
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [18:0][6:0]            pend_in;   // Written input parameters.
    logic [18:0][6:0]            act_in;    // Latched input parameters in use.
    logic [1:0][6:0]             pend_out;  // Written output parameters.
    logic [1:0][6:0]             act_out;   // Latched output parameters in use.
    logic [3:0]                  status;    // Sticky events.
    logic [3:0]                  mask;      // Interrupt mask.
    logic [31:0]                 rdata;     // Read data register.
    logic [4:0]                  sync1;     // First synchroniser stage.
    logic [4:0]                  sync2;     // Second synchroniser stage.
    logic [4:0]                  sync3;     // Third synchroniser stage.
    logic [4:0]                  phys_q;    // Accepted terminal levels.
    logic [1:0]                  out_term;  // Output terminal levels.
    logic [sio_pkg::FUNC_N-1:0]  func;      // Routed input functions.
    sio_pkg::sio_iq_fix_s        fix;       // Registered fixed commands.
    sio_pkg::sio_iq_out_s        iq_out;    // Registered fixed outputs.
  } sio_state_s;

  sio_state_s                  st_ff;       // Current state.
  sio_state_s                  nxt_st;      // Next state.
  logic [sio_pkg::FUNC_N-1:0]  routed;      // Router output.
  logic [18:0]                 levels;      // Slot levels fed to the router.
  logic [18:0][6:0]            def_in;      // Reset assignment for this variant.

  assign def_in = VARIANT_B ? sio_pkg::DEF_IN_B : sio_pkg::DEF_IN_A;

  // Physical slots first, then the image-area slot bits.
  assign levels = {iq_in.slot, st_ff.phys_q};

  // ---------------------------------------------------------------------------
  // Routing
  // ---------------------------------------------------------------------------
  // Only the latched copy reaches the router, never the pending one.
  sio_slot_router u_router (
    .var_b    (VARIANT_B),
    .codes    (st_ff.act_in),
    .levels   (levels),
    .func_vec (routed)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Register access, terminal sampling, latch on power-up and output selection.
  always_comb begin
    logic [3:0] set_ev;
    logic [6:0] code;
    logic [4:0] idx;
    set_ev = '0;
    code   = '0;
    idx    = '0;
    nxt_st = st_ff;

    // Terminals pass three flops; a level is taken once stages two and three agree.
    nxt_st.sync1 = phys_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    for (int i = 0; i < 5; i++) begin
      if (st_ff.sync2[i] == st_ff.sync3[i]) begin
        nxt_st.phys_q[i] = st_ff.sync3[i];
      end
    end

    // Pending parameter writes; the running routing is untouched.
    if (wr) begin
      idx = addr[6:2];
      if (addr < sio_pkg::REG_OUT_BASE && addr[1:0] == 2'b00) begin
        if ((VARIANT_B && idx < 5'd19) || idx < 5'd7) begin
          nxt_st.pend_in[idx] = wdata[6:0];
          set_ev[sio_pkg::ST_WRITTEN] = 1'b1;
        end
      end else if (addr == sio_pkg::REG_OUT_BASE || addr == sio_pkg::REG_OUT_BASE + 8'h04) begin
        nxt_st.pend_out[addr[2]] = wdata[6:0];
        set_ev[sio_pkg::ST_WRITTEN] = 1'b1;
      end else if (addr == sio_pkg::REG_MASK) begin
        nxt_st.mask = wdata[3:0];
      end
    end

    // Power-up latch: every code is checked against its slot's list.
    if (power_load) begin
      set_ev[sio_pkg::ST_LOADED] = 1'b1;
      for (int i = 0; i < 19; i++) begin
        code = st_ff.pend_in[i];
        if (sio_pkg::in_code_ok(VARIANT_B, 5'(i), code)) begin
          nxt_st.act_in[i] = code;
        end else begin
          nxt_st.act_in[i] = sio_pkg::CODE_NONE;
          if (code != sio_pkg::CODE_NONE) begin
            set_ev[sio_pkg::ST_IN_ERR] = 1'b1;
          end
        end
      end
      for (int j = 0; j < 2; j++) begin
        code = st_ff.pend_out[j];
        if (sio_pkg::out_code_ok(code)) begin
          nxt_st.act_out[j] = code;
        end else begin
          nxt_st.act_out[j] = sio_pkg::CODE_NONE;
          if (code != sio_pkg::CODE_NONE) begin
            set_ev[sio_pkg::ST_OUT_ERR] = 1'b1;
          end
        end
      end
    end

    // Sticky status: write one clears, but a new event in the same cycle wins.
    if (wr && addr == sio_pkg::REG_STATUS) begin
      nxt_st.status = st_ff.status & ~wdata[3:0];
    end
    nxt_st.status = nxt_st.status | set_ev;

    // Output terminals follow the status selected by their latched code.
    for (int j = 0; j < 2; j++) begin
      code = st_ff.act_out[j];
      if (code == sio_pkg::CODE_NONE) begin
        nxt_st.out_term[j] = 1'b0;
      end else if (code == sio_pkg::CODE_THRU_A) begin
        nxt_st.out_term[j] = st_ff.phys_q[0];
      end else if (code == sio_pkg::CODE_THRU_B) begin
        nxt_st.out_term[j] = st_ff.phys_q[1];
      end else begin
        nxt_st.out_term[j] = status_vec[code];
      end
    end

    // Routed input functions and the fixed image-area inputs.
    nxt_st.func = routed;
    nxt_st.fix  = iq_in.fix;

    // Fixed image-area outputs, which no parameter can move.
    nxt_st.iq_out.ready          = status_vec[1];
    nxt_st.iq_out.in_position    = status_vec[2];
    nxt_st.iq_out.write_done     = status_vec[13];
    nxt_st.iq_out.read_done      = aux_status.read_done;
    nxt_st.iq_out.alarm          = status_vec[16];
    nxt_st.iq_out.homing_done    = status_vec[22];
    nxt_st.iq_out.zero_dev       = status_vec[23];
    nxt_st.iq_out.zero_speed     = status_vec[24];
    nxt_st.iq_out.trq_limit      = status_vec[26];
    nxt_st.iq_out.data_err       = status_vec[30];
    nxt_st.iq_out.preset_done    = status_vec[75];
    nxt_st.iq_out.alarm_code     = status_vec[36:32];
    nxt_st.iq_out.toggle_ans     = status_vec[43:42];
    nxt_st.iq_out.toggle_err     = status_vec[44];
    nxt_st.iq_out.estop_det      = status_vec[41];
    nxt_st.iq_out.zphase_det     = aux_status.zphase_det;
    nxt_st.iq_out.irq_pos_det    = aux_status.irq_pos_det;
    nxt_st.iq_out.dev_over       = aux_status.dev_over;
    nxt_st.iq_out.cmd_pulse_zero = aux_status.cmd_pulse_zero;
    nxt_st.iq_out.in_through     = st_ff.phys_q;
    nxt_st.iq_out.select_echo    = iq_in.fix.select_bit;

    // Read data stands only in the cycle after the strobe; unmapped reads give zero.
    nxt_st.rdata = '0;
    if (rd) begin
      idx = addr[6:2];
      if (addr < sio_pkg::REG_OUT_BASE && addr[1:0] == 2'b00 && idx < 5'd19) begin
        nxt_st.rdata = {25'h000_0000, st_ff.pend_in[idx]};
      end else if (addr >= sio_pkg::REG_ACT_IN && addr < sio_pkg::REG_ACT_OUT
                   && addr[1:0] == 2'b00 && addr[6:2] < 5'd19) begin
        nxt_st.rdata = {25'h000_0000, st_ff.act_in[5'(addr[6:2] - 5'd0)]};
      end else begin
        unique case (addr)
          sio_pkg::REG_OUT_BASE:         nxt_st.rdata = {25'h000_0000, st_ff.pend_out[0]};
          sio_pkg::REG_OUT_BASE + 8'h04: nxt_st.rdata = {25'h000_0000, st_ff.pend_out[1]};
          sio_pkg::REG_ACT_OUT:          nxt_st.rdata = {25'h000_0000, st_ff.act_out[0]};
          sio_pkg::REG_ACT_OUT + 8'h04:  nxt_st.rdata = {25'h000_0000, st_ff.act_out[1]};
          sio_pkg::REG_STATUS:           nxt_st.rdata = {28'h000_0000, st_ff.status};
          sio_pkg::REG_MASK:             nxt_st.rdata = {28'h000_0000, st_ff.mask};
          sio_pkg::REG_LIVE:             nxt_st.rdata = {25'h000_0000, st_ff.out_term,
                                                         st_ff.phys_q};
          default:                       nxt_st.rdata = '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Reset brings back the default assignments in both copies.
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff          <= '0;
      st_ff.pend_in  <= def_in;
      st_ff.act_in   <= def_in;
      st_ff.pend_out <= sio_pkg::DEF_OUT;
      st_ff.act_out  <= sio_pkg::DEF_OUT;
      st_ff.status   <= sio_pkg::STATUS_RST;
      st_ff.mask     <= sio_pkg::MASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rdata       = st_ff.rdata;
  assign irq         = |(st_ff.status & st_ff.mask);
  assign func_active = st_ff.func;
  assign fixed_cmd   = st_ff.fix;
  assign out_term    = st_ff.out_term;
  assign iq_out      = st_ff.iq_out;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  hold_active_a: assert property (!power_load |=> $stable(st_ff.act_in))
    else $error("active input codes changed without a power-up latch");

  latch_error_a: assert property (power_load && st_ff.pend_in[1] != 7'h00 &&
      !sio_pkg::in_code_ok(VARIANT_B, 5'd1, st_ff.pend_in[1])
      |=> st_ff.status[0] && st_ff.act_in[1] == 7'h00)
    else $error("illegal code was not rejected at latch time");

  code_range_a: assert property (power_load |=>
      st_ff.act_in[0] <= (VARIANT_B ? sio_pkg::CODE_MAX_B : sio_pkg::CODE_MAX_A))
    else $error("latched code outside the accepted range");

  zero_output_a: assert property ($past(st_ff.act_out[0]) == 7'h00 |-> !out_term[0])
    else $error("unassigned output terminal is active");

  out_select_a: assert property (st_ff.act_out[1] == 7'h10 |=>
      out_term[1] == $past(status_vec[16]))
    else $error("output terminal does not follow its selected status");

  slot_route_a: assert property (st_ff.act_in[0] == 7'h0A && st_ff.phys_q[0] |=>
      func_active[10])
    else $error("bound terminal did not raise its function");

  pin_sync_a: assert property ($stable(phys_in) [*5] |-> st_ff.phys_q == phys_in)
    else $error("settled terminal level not taken after the synchroniser");

  through_out_a: assert property (##1 iq_out.in_through == $past(st_ff.phys_q))
    else $error("image pass-through of terminals is wrong");

  fixed_input_a: assert property (##1 fixed_cmd == $past(iq_in.fix))
    else $error("fixed image inputs are not forwarded");

  img_slot_a: assert property (!VARIANT_B && st_ff.act_in[5] == 7'h11 && iq_in.slot[0]
      |=> func_active[17])
    else $error("image slot six did not raise its function");

  read_window_a: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data present outside the read answer cycle");

endmodule

// >>> rtl/sio_pkg.sv
// Package with constants, types and decode functions for the servo I/O signal assignment block.
package sio_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_SLOTS    = 19;           // Input slots of the larger variant.
  localparam int unsigned NUM_PHYS     = 5;            // Physical sequence input terminals.
  localparam int unsigned NUM_IMG      = 14;           // Image-area slots (slot 6 onward).
  localparam int unsigned NUM_OUTS     = 2;            // Physical output terminals.
  localparam int unsigned CODE_W       = 7;            // Width of a function code.
  localparam int unsigned FUNC_N       = 128;          // Size of the function vectors.

  // ---------------------------------------------------------------------------
  // Code ranges and special codes
  // ---------------------------------------------------------------------------
  localparam logic [6:0] CODE_MAX_A    = 7'h3A;        // First variant accepts 1 to 58.
  localparam logic [6:0] CODE_MAX_B    = 7'h4C;        // Second variant accepts 1 to 76.
  localparam logic [6:0] CODE_THRU_A   = 7'h5B;        // Output code 91, copy of terminal one.
  localparam logic [6:0] CODE_THRU_B   = 7'h5C;        // Output code 92, copy of terminal two.
  localparam logic [6:0] CODE_NONE     = 7'h00;        // Unassigned slot.

  // ---------------------------------------------------------------------------
  // Register map (byte addresses) and status bit positions
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_IN_BASE   = 8'h00;        // Pending input parameters, 4 bytes each.
  localparam logic [7:0] REG_OUT_BASE  = 8'h50;        // Pending output parameters.
  localparam logic [7:0] REG_STATUS    = 8'h60;        // Sticky events, write one to clear.
  localparam logic [7:0] REG_MASK      = 8'h64;        // Interrupt mask, same layout.
  localparam logic [7:0] REG_LIVE      = 8'h68;        // Live terminal levels.
  localparam logic [7:0] REG_ACT_IN    = 8'h80;        // Active (latched) input parameters.
  localparam logic [7:0] REG_ACT_OUT   = 8'hD0;        // Active (latched) output parameters.
  localparam int unsigned ST_IN_ERR    = 0;            // Bad input code found at latch time.
  localparam int unsigned ST_OUT_ERR   = 1;            // Bad output code found at latch time.
  localparam int unsigned ST_WRITTEN   = 2;            // A parameter was written since last cleared.
  localparam int unsigned ST_LOADED    = 3;            // New parameters were latched.
  localparam int unsigned ST_W         = 4;            // Width of status and mask.
  localparam logic [3:0] STATUS_RST    = 4'h0;         // Status after reset.
  localparam logic [3:0] MASK_RST      = 4'h0;         // Mask after reset.

  // ---------------------------------------------------------------------------
  // Default assignments after reset, slot one at index 0
  // ---------------------------------------------------------------------------
  localparam logic [18:0][6:0] DEF_IN_A = {{18{7'h00}}, 7'h31};
  localparam logic [18:0][6:0] DEF_IN_B = {7'h00, 7'h00, 7'h00, 7'h0A, 7'h09, 7'h00, 7'h00,
                                           7'h33, 7'h05, 7'h04, 7'h0B, 7'h03, 7'h02, 7'h01,
                                           7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  localparam logic [1:0][6:0]  DEF_OUT  = {7'h00, 7'h00};

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  // Image-area input bits whose functions never move.
  typedef struct packed {
    logic       servo_on;
    logic       forward_command;
    logic       reverse_command;
    logic       homing_command;
    logic       forced_stop;
    logic       alarm_reset;
    logic       write_cmd;
    logic       read_cmd;
    logic       pos_preset;
    logic       pos_ctrl;
    logic       trq_ctrl;
    logic       irq_enable;
    logic       dev_clear;
    logic       free_run;
    logic [1:0] toggle_mon;
    logic       pos_cmd_op;
    logic       zphase_cmd;
    logic       irq_pos_cmd;
    logic [2:0] select_bit;
  } sio_iq_fix_s;

  // Whole image-area input word from the controller.
  typedef struct packed {
    logic [13:0] slot;                                 // Reassignable slot bits, slot 6 at bit 0.
    sio_iq_fix_s fix;
  } sio_iq_in_s;

  // Internal status that has no selectable code.
  typedef struct packed {
    logic read_done;
    logic zphase_det;
    logic irq_pos_det;
    logic dev_over;
    logic cmd_pulse_zero;
  } sio_aux_s;

  // Fixed image-area output bits.
  typedef struct packed {
    logic       ready;
    logic       in_position;
    logic       write_done;
    logic       read_done;
    logic       alarm;
    logic       homing_done;
    logic       zero_dev;
    logic       zero_speed;
    logic       trq_limit;
    logic       data_err;
    logic       preset_done;
    logic [4:0] alarm_code;
    logic [1:0] toggle_ans;
    logic       toggle_err;
    logic       estop_det;
    logic       zphase_det;
    logic       irq_pos_det;
    logic       dev_over;
    logic       cmd_pulse_zero;
    logic [4:0] in_through;
    logic [2:0] select_echo;
  } sio_iq_out_s;

  // ---------------------------------------------------------------------------
  // Decode functions
  // ---------------------------------------------------------------------------
  // True when the code may be bound to the given input slot (0-based).
  function automatic logic in_code_ok(input logic var_b, input logic [4:0] slot,
                                      input logic [6:0] code);
    logic ok;
    ok = 1'b0;
    if (var_b) begin
      ok = (code != CODE_NONE) && (code <= CODE_MAX_B) && (slot < 5'd19);
    end else if (slot < 5'd5) begin
      ok = code inside {7'h01, 7'h06, 7'h07, 7'h08, 7'h0A, 7'h22, 7'h31};
    end else if (slot < 5'd7) begin
      ok = code inside {7'h0E, 7'h11, 7'h13, 7'h14, 7'h1D, 7'h20, 7'h39, 7'h3A};
    end
    return ok;
  endfunction

  // True when the code may drive an output terminal.
  function automatic logic out_code_ok(input logic [6:0] code);
    return code inside {7'h01, 7'h02, 7'h0B, 7'h0E, 7'h10, 7'h14, [7'h16:7'h1C],
                        [7'h20:7'h24], [7'h26:7'h29], 7'h2D, 7'h2E, 7'h4B, 7'h4C,
                        7'h5B, 7'h5C};
  endfunction

endpackage

// >>> rtl/sio_slot_router.sv
// Routes every input slot level onto the function vector by its bound code.
module sio_slot_router (
  input  wire logic                         var_b,    // High for the 19-slot variant.
  input  wire logic [18:0][6:0]             codes,    // Active code of each slot.
  input  wire logic [18:0]                  levels,   // Current level of each slot.
  output logic      [sio_pkg::FUNC_N-1:0]   func_vec  // One bit per function code.
);

  // ---------------------------------------------------------------------------
  // Per-slot decode
  // ---------------------------------------------------------------------------
  logic [18:0][sio_pkg::FUNC_N-1:0] slot_hit;         // One-hot image of each slot.

  // Each slot drives one bit; an illegal or zero code drives none.
  for (genvar g = 0; g < 19; g++) begin : g_slot
    always_comb begin
      slot_hit[g] = '0;
      if (levels[g] && sio_pkg::in_code_ok(var_b, 5'(g), codes[g])) begin
        slot_hit[g][codes[g]] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Merge
  // ---------------------------------------------------------------------------
  // Two slots bound to one code act as a wired OR, so either may raise it.
  always_comb begin
    func_vec = '0;
    for (int i = 0; i < 19; i++) begin
      func_vec = func_vec | slot_hit[i];
    end
  end

endmodule

// >>> testbench/sio_ctrl_model.sv
// Controller model that fills the image-area input word seen by the block.
module sio_ctrl_model (
  input  wire logic                 mclk,          // Shared clock.
  input  wire logic [13:0]          slot_req,      // Slot bits the bench asks for.
  input  wire sio_pkg::sio_iq_fix_s fix_req,       // Fixed bits the bench asks for.
  output sio_pkg::sio_iq_in_s       iq_in = '0     // Image word towards the block.
);
  timeunit 1ns;
  timeprecision 100ps;
  // The word moves only on an edge, like the controller's scan, so no glitch reaches the block.
  always @(posedge mclk) begin
    iq_in <= '{slot: slot_req, fix: fix_req};
  end
endmodule

// >>> testbench/tb.sv
// Self-checking testbench for the servo I/O signal assignment block.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: %s", $time, m); end end
  logic                 mclk = 0, reset = 1, power_load = 0, wr = 0, rd = 0, irq;
  logic [7:0]           addr = '0;
  logic [31:0]          wdata = '0, rdata, rv;
  logic [4:0]           phys_in = '0;
  logic [13:0]          slot_req = '0;
  logic [127:0]         status_vec = '0, func_active;
  logic [1:0]           out_term;
  sio_pkg::sio_iq_fix_s fix_req = '0, fixed_cmd;
  sio_pkg::sio_iq_in_s  iq_in;
  sio_pkg::sio_aux_s    aux_status = '0;
  sio_pkg::sio_iq_out_s iq_out;
  int                   errors = 0, checks = 0;
  always #12.5 mclk = ~mclk;
  sio_ctrl_model PLC (.mclk(mclk), .slot_req(slot_req), .fix_req(fix_req), .iq_in(iq_in));
  sio_signal_assign DUT (.mclk(mclk), .reset(reset), .power_load(power_load), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .phys_in(phys_in),
    .iq_in(iq_in), .status_vec(status_vec), .aux_status(aux_status),
    .func_active(func_active), .fixed_cmd(fixed_cmd), .out_term(out_term), .iq_out(iq_out));
  // Bus cycles end on an edge, so the next one always leaves a gap and no strobe is set twice.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge mclk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk) begin addr <= a; rd <= 1'b1; end
    @(posedge mclk) rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // A power cycle, then enough edges for the pin filter and routing to settle.
  task automatic load();
    @(posedge mclk) power_load <= 1'b1;
    @(posedge mclk) power_load <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask
  task automatic t_latch();
    rd_reg(8'h80);
    `CHK(rv, 32'h0000_0031, "default of slot one")
    wr_reg(8'h00, 32'h0000_000A);
    rd_reg(8'h80);
    `CHK(rv, 32'h0000_0031, "active code changed early")
    @(posedge mclk) phys_in[0] <= 1'b1;
    load();
    `CHK(func_active[10], 1'b1, "terminal not routed")
    `CHK(func_active[49], 1'b0, "old function kept")
  endtask
  task automatic t_illegal();
    wr_reg(8'h04, 32'h0000_000E);
    wr_reg(8'h14, 32'h0000_0001);
    wr_reg(8'h18, 32'h0000_000E);
    slot_req <= 14'h0003;
    load();
    `CHK(func_active[14], 1'b1, "image slot not routed")
    `CHK(func_active[1], 1'b0, "bad code routed")
    rd_reg(8'h84);
    `CHK(rv, 32'h0000_0000, "bad physical code kept")
    wr_reg(8'h64, 32'h0000_0001);
    #1;
    `CHK(irq, 1'b1, "error not raised")
    wr_reg(8'h60, 32'h0000_0001);
    @(posedge mclk) #1;
    `CHK(irq, 1'b0, "error not cleared")
  endtask
  task automatic t_out();
    wr_reg(8'h50, 32'h0000_005B);
    wr_reg(8'h54, 32'h0000_0010);
    wr_reg(8'h14, 32'h0000_0011);
    status_vec[16] <= 1'b1;
    load();
    `CHK(out_term, 2'b11, "pass-through or selected status wrong")
    `CHK(func_active[17], 1'b1, "image slot six not routed")
    `CHK(iq_out.in_through, 5'h01, "fixed pass-through wrong")
    wr_reg(8'h50, 32'h0000_0000);
    load();
    `CHK(out_term, 2'b10, "unassigned output active")
  endtask
  task automatic t_fixed();
    @(posedge mclk) begin fix_req.forced_stop <= 1'b1; aux_status.dev_over <= 1'b1; end
    repeat (3) @(posedge mclk);
    #1;
    `CHK(fixed_cmd.forced_stop, 1'b1, "fixed input lost")
    `CHK(iq_out.dev_over, 1'b1, "fixed output lost")
  endtask
  // ---------------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_latch();
    t_illegal();
    t_out();
    t_fixed();
    test_done();
  end
  // The run needs some 76 cycles; this limit leaves ample room.
  initial begin
    #50us;
    errors++;
    test_done();
  end
  task automatic test_done();
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
endmodule
